/* verilog/cache_pkg.sv */
/*
 Constants, register map and state type for the unified cache with SRAM mode.
 Assumes a 32-bit byte address space and word-only processor accesses.
*/
`default_nettype none
package cache_pkg;
   // Geometry: 4 ways x 128 lines x 4 words of 32 bits
   localparam int WAYS = 4;
   localparam int LINES = 128;
   localparam int WORDS = 4;
   localparam int TAG_W = 21;
   // Internal memory region, compared against address bits [31:15]
   localparam logic [16:0] INT_REGION = 17'h02000;
   // Software register byte addresses
   localparam logic [31:0] CFG_ADDR = 32'h01C00000;
   localparam logic [31:0] WIN0_ADDR = 32'h01C00004;
   localparam logic [31:0] WIN1_ADDR = 32'h01C00008;
   // System configuration register layout
   localparam logic [7:0] CFG_RESET = 8'h01;
   localparam logic [7:0] CFG_WMASK = 8'h3F;
   localparam int MODE_LSB = 1;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_HALF = 2'h1;
   localparam logic [1:0] MODE_FULL = 2'h3;
   // Window register layout: 4KB block numbers
   localparam logic [31:0] WIN_RESET = 32'h00000000;
   localparam int WIN_START_LSB = 0;
   localparam int WIN_END_LSB = 16;
   localparam int BLK_LSB = 12;
   localparam int BLK_W = 16;
   // Set-state codes of the fill sequence
   localparam logic [3:0] CS_EMPTY = 4'h0;
   localparam logic [3:0] CS_ONE = 4'h6;
   localparam logic [3:0] CS_TWO = 4'h3;
   localparam logic [3:0] CS_THREE = 4'h5;
   localparam logic [3:0] CS_FULL = 4'h8;
   // Last word of a line fill
   localparam logic [1:0] LAST_WORD = 2'h3;
   // Access sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_RESP, ST_FILL, ST_BYPASS, ST_WRITE} cstate_t;
endpackage
`default_nettype wire

/* verilog/set_state_logic.sv */
/*
 Per-line set-state decoder: valid ways, victim way and next state.
 Purely combinational; the caller supplies the half-cache flag.
*/
`default_nettype none
module set_state_logic (
   input wire logic [3:0] cs,
   input wire logic half,
   input wire logic [1:0] upd_way,
   input wire logic upd_fill,
   output logic [3:0] valid_mask,
   output logic [1:0] victim,
   output logic [3:0] cs_next
);
   // Tree state pointing away from the way just used
   logic [3:0] away;

   // Group bit points to the other group, the way bit to the other way
   always_comb
   begin
      away[3] = 1'b1;
      away[2] = ~upd_way[1];
      away[1] = upd_way[1] ? cs[1] : ~upd_way[0];
      away[0] = upd_way[1] ? ~upd_way[0] : cs[0];
   end

   // Valid ways follow the fill sequence; half mode drops ways 2 and 3
   always_comb
   begin
      if (cs[3])
         valid_mask = 4'hF;
      else if (cs == cache_pkg::CS_ONE)
         valid_mask = 4'h1;
      else if (cs == cache_pkg::CS_TWO)
         valid_mask = 4'h5;
      else if (cs == cache_pkg::CS_THREE)
         valid_mask = 4'h7;
      else
         valid_mask = 4'h0;
      if (half)
         valid_mask = valid_mask & 4'h3;
   end

   // Victim: fill order while filling, tree bits once all valid
   always_comb
   begin
      if (cs[3])
      begin
         if (half)
            victim = {1'b0, cs[1]};
         else
            victim = cs[2] ? {1'b1, cs[0]} : {1'b0, cs[1]};
      end
      else if (cs == cache_pkg::CS_ONE)
         victim = half ? 2'h1 : 2'h2;
      else if (cs == cache_pkg::CS_TWO && !half)
         victim = 2'h1;
      else if (cs == cache_pkg::CS_THREE && !half)
         victim = 2'h3;
      else
         victim = 2'h0;
   end

   // Fills walk the sequence; hits only move the tree when all valid
   always_comb
   begin
      if (!upd_fill)
         cs_next = cs[3] ? away : cs;
      else if (cs[3])
         cs_next = away;
      else if (cs == cache_pkg::CS_ONE)
         cs_next = half ? cache_pkg::CS_FULL : cache_pkg::CS_TWO;
      else if (cs == cache_pkg::CS_TWO && !half)
         cs_next = cache_pkg::CS_THREE;
      else if (cs == cache_pkg::CS_THREE && !half)
         cs_next = cache_pkg::CS_FULL;
      else
         cs_next = cache_pkg::CS_ONE;
   end
endmodule
`default_nettype wire

/* verilog/unified_cache.sv */
/*
 Unified write-through cache with internal SRAM mode, between core and memory bus.
 Assumes the core holds its request stable until cpu_ready, and that the
 memory bus holds nothing itself: one mem_ack pulse answers each word.
*/
`default_nettype none
module unified_cache (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic [31:0] cpu_rdata,
   output logic cpu_ready,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack
);
   // Storage: one shared store for code and data
   logic [31:0] data_mem [0:cache_pkg::WAYS*cache_pkg::LINES*cache_pkg::WORDS-1];
   logic [cache_pkg::TAG_W-1:0] tag_mem [0:cache_pkg::WAYS*cache_pkg::LINES-1];
   logic [3:0] lru_mem [0:cache_pkg::LINES-1];
   // Software registers
   logic [7:0] cfg_q;
   logic [31:0] win0_q;
   logic [31:0] win1_q;
   logic [31:0] reg_rdata_q;
   // Sequencer and bus state
   cache_pkg::cstate_t state_q;
   logic [1:0] fill_cnt_q;
   logic [1:0] victim_q;
   logic [31:0] mem_addr_q;
   logic [31:0] mem_wdata_q;
   logic [31:0] rdata_q;
   // Address fields
   logic [cache_pkg::TAG_W-1:0] req_tag;
   logic [6:0] line;
   logic [1:0] word;
   logic [1:0] iway;
   logic [cache_pkg::BLK_W-1:0] blk;
   // Decode and lookup
   logic [1:0] mode;
   logic cache_en, half;
   logic int_sel, is_lru, is_tag, is_data;
   logic data_ok, tag_ok;
   logic in_win, cacheable, idle_req, fill_end;
   logic [3:0] cs, valid_mask, cs_next, hit_vec;
   logic [1:0] victim, hit_way, upd_way;
   logic hit, upd_fill;
   logic [31:0] hit_data, int_rdata;
   // Data array write port
   logic dwr_en;
   logic [10:0] dwr_idx;
   logic [31:0] dwr_data;

   assign mode = cfg_q[cache_pkg::MODE_LSB +: 2];
   // Reserved mode 10 disables caching but, unlike off, opens no SRAM data ways
   assign cache_en = (mode == cache_pkg::MODE_HALF) || (mode == cache_pkg::MODE_FULL);
   assign half = (mode == cache_pkg::MODE_HALF);
   assign req_tag = cpu_addr[31:11];
   assign line = cpu_addr[10:4];
   assign word = cpu_addr[3:2];
   assign iway = cpu_addr[12:11];
   assign blk = cpu_addr[cache_pkg::BLK_LSB +: cache_pkg::BLK_W];
   // Internal region: data ways, then tags, then set-state memory
   assign int_sel = (cpu_addr[31:15] == cache_pkg::INT_REGION);
   assign is_lru = cpu_addr[14];
   assign is_tag = !cpu_addr[14] && cpu_addr[13];
   assign is_data = !cpu_addr[14] && !cpu_addr[13];
   // SRAM ways: all when off, 2 and 3 in half mode, none in full mode
   assign data_ok = (mode == cache_pkg::MODE_OFF) || (half && iway[1]);
   assign tag_ok = !cache_en;
   // Window test: start block inclusive, end block exclusive
   assign in_win = (blk >= win0_q[cache_pkg::WIN_START_LSB +: cache_pkg::BLK_W]
                    && blk < win0_q[cache_pkg::WIN_END_LSB +: cache_pkg::BLK_W])
                || (blk >= win1_q[cache_pkg::WIN_START_LSB +: cache_pkg::BLK_W]
                    && blk < win1_q[cache_pkg::WIN_END_LSB +: cache_pkg::BLK_W]);
   assign cacheable = cache_en && !in_win;
   assign idle_req = (state_q == cache_pkg::ST_IDLE) && cpu_req;
   assign fill_end = (state_q == cache_pkg::ST_FILL) && mem_ack
                     && (fill_cnt_q == cache_pkg::LAST_WORD);
   assign cs = lru_mem[line];

   // Tag match per way, only for ways the set-state marks valid
   for (genvar w = 0; w < cache_pkg::WAYS; w++)
   begin : g_hit
      assign hit_vec[w] = valid_mask[w] && (tag_mem[{2'(w), line}] == req_tag);
   end
   assign hit = cache_en && !int_sel && (hit_vec != 4'h0);
   assign hit_way = {hit_vec[3] | hit_vec[2], hit_vec[3] | hit_vec[1]};
   assign hit_data = data_mem[{hit_way, line, word}];
   assign upd_fill = (state_q == cache_pkg::ST_FILL);
   assign upd_way = upd_fill ? victim_q : hit_way;

   // Set-state decode of the addressed line
   set_state_logic u_set_state (
      .cs(cs),
      .half(half),
      .upd_way(upd_way),
      .upd_fill(upd_fill),
      .valid_mask(valid_mask),
      .victim(victim),
      .cs_next(cs_next)
   );

   // Internal reads; forbidden areas read as zero
   always_comb
   begin
      int_rdata = 32'h00000000;
      if (is_lru && tag_ok)
         int_rdata = {28'h0000000, cs};
      else if (is_tag && tag_ok)
         int_rdata = {tag_mem[{iway, line}], 11'h000};
      else if (is_data && data_ok)
         int_rdata = data_mem[{iway, line, word}];
   end

   // Software register writes
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg_q <= cache_pkg::CFG_RESET;
         win0_q <= cache_pkg::WIN_RESET;
         win1_q <= cache_pkg::WIN_RESET;
      end
      else if (reg_write)
      begin
         if (reg_addr == cache_pkg::CFG_ADDR)
            cfg_q <= reg_wdata[7:0] & cache_pkg::CFG_WMASK;
         else if (reg_addr == cache_pkg::WIN0_ADDR)
            win0_q <= reg_wdata;
         else if (reg_addr == cache_pkg::WIN1_ADDR)
            win1_q <= reg_wdata;
      end
   end

   // Register read data stands one cycle only; unmapped reads give zero
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         reg_rdata_q <= 32'h00000000;
      else if (!reg_read)
         reg_rdata_q <= 32'h00000000;
      else if (reg_addr == cache_pkg::CFG_ADDR)
         reg_rdata_q <= {24'h000000, cfg_q};
      else if (reg_addr == cache_pkg::WIN0_ADDR)
         reg_rdata_q <= win0_q;
      else if (reg_addr == cache_pkg::WIN1_ADDR)
         reg_rdata_q <= win1_q;
      else
         reg_rdata_q <= 32'h00000000;
   end
   assign reg_rdata = reg_rdata_q;

   // Access sequencer
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         state_q <= cache_pkg::ST_IDLE;
      else
         unique case (state_q)
            cache_pkg::ST_IDLE:
               if (cpu_req)
               begin
                  if (int_sel)
                     state_q <= cache_pkg::ST_RESP;
                  else if (cpu_we)
                     state_q <= cache_pkg::ST_WRITE;
                  else if (hit)
                     state_q <= cache_pkg::ST_RESP;
                  else if (cacheable)
                     state_q <= cache_pkg::ST_FILL;
                  else
                     state_q <= cache_pkg::ST_BYPASS;
               end
            cache_pkg::ST_RESP:
               state_q <= cache_pkg::ST_IDLE;
            cache_pkg::ST_FILL:
               if (fill_end)
                  state_q <= cache_pkg::ST_RESP;
            cache_pkg::ST_BYPASS, cache_pkg::ST_WRITE:
               if (mem_ack)
                  state_q <= cache_pkg::ST_RESP;
         endcase
   end

   // External address, data, word count and victim
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_addr_q <= 32'h00000000;
         mem_wdata_q <= 32'h00000000;
         fill_cnt_q <= 2'h0;
         victim_q <= 2'h0;
      end
      else if (idle_req && !int_sel)
      begin
         fill_cnt_q <= 2'h0;
         victim_q <= victim;
         mem_wdata_q <= cpu_wdata;
         // Fills start at word 0 of the line
         if (!cpu_we && !hit && cacheable)
            mem_addr_q <= {cpu_addr[31:4], 4'h0};
         else
            mem_addr_q <= {cpu_addr[31:2], 2'h0};
      end
      else if (upd_fill && mem_ack)
      begin
         fill_cnt_q <= fill_cnt_q + 2'h1;
         mem_addr_q <= {mem_addr_q[31:4], fill_cnt_q + 2'h1, 2'h0};
      end
   end
   assign mem_req = (state_q == cache_pkg::ST_FILL) || (state_q == cache_pkg::ST_BYPASS)
                    || (state_q == cache_pkg::ST_WRITE);
   assign mem_we = (state_q == cache_pkg::ST_WRITE);
   assign mem_addr = mem_addr_q;
   assign mem_wdata = mem_wdata_q;

   // Read data to the core
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         rdata_q <= 32'h00000000;
      else if (idle_req && !cpu_we && int_sel)
         rdata_q <= int_rdata;
      else if (idle_req && !cpu_we && hit)
         rdata_q <= hit_data;
      else if (upd_fill && mem_ack && fill_cnt_q == word)
         rdata_q <= mem_rdata; // Critical word captured in passing
      else if ((state_q == cache_pkg::ST_BYPASS) && mem_ack)
         rdata_q <= mem_rdata;
   end
   assign cpu_rdata = rdata_q;
   assign cpu_ready = (state_q == cache_pkg::ST_RESP);

   // One data write port shared by fills, write hits and SRAM writes
   always_comb
   begin
      dwr_en = 1'b0;
      dwr_idx = {hit_way, line, word};
      dwr_data = cpu_wdata;
      if (upd_fill && mem_ack)
      begin
         dwr_en = 1'b1;
         dwr_idx = {victim_q, line, fill_cnt_q};
         dwr_data = mem_rdata;
      end
      else if (idle_req && cpu_we && int_sel)
      begin
         dwr_en = is_data && data_ok;
         dwr_idx = {iway, line, word};
      end
      else if (idle_req && cpu_we)
         dwr_en = hit;
   end

   // Data store has no reset; contents are valid only through set-state
   always_ff @(posedge clock)
   begin
      if (dwr_en)
         data_mem[dwr_idx] <= dwr_data;
   end

   // Tag store: written by fills, or by software while disabled
   always_ff @(posedge clock)
   begin
      if (fill_end)
         tag_mem[{victim_q, line}] <= req_tag;
      else if (idle_req && cpu_we && int_sel && is_tag && tag_ok)
         tag_mem[{iway, line}] <= cpu_wdata[31:11];
   end

   // Set-state store; mode changes never touch it
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < cache_pkg::LINES; i++)
            lru_mem[i] <= cache_pkg::CS_EMPTY;
      end
      else if (fill_end)
         lru_mem[line] <= cs_next;
      else if (idle_req && !cpu_we && hit)
         lru_mem[line] <= cs_next;
      else if (idle_req && cpu_we && int_sel && is_lru && tag_ok)
         lru_mem[line] <= cpu_wdata[3:0];
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   fill_word_order_a: assert property (
      upd_fill |-> mem_addr_q[3:2] == fill_cnt_q && mem_addr_q[31:4] == cpu_addr[31:4])
      else $error("fill word address out of order");
   write_through_a: assert property (
      idle_req && cpu_we && !int_sel |=> mem_req && mem_we && mem_addr == {$past(cpu_addr[31:2]), 2'h0})
      else $error("write did not reach external memory");
   first_fill_state_a: assert property (
      fill_end && cs == cache_pkg::CS_EMPTY |=> lru_mem[$past(line)] == cache_pkg::CS_ONE)
      else $error("first fill did not set state 0110");
   tree_victim_a: assert property (
      idle_req && !cpu_we && !int_sel && !hit && cacheable && !half && cs[3]
      |=> victim_q == ($past(cs[2]) ? {1'b1, $past(cs[0])} : {1'b0, $past(cs[1])}))
      else $error("wrong victim for full line");
   disabled_bypass_a: assert property (
      idle_req && !cpu_we && !int_sel && !cache_en |=> state_q == cache_pkg::ST_BYPASS)
      else $error("disabled read not sent outside");
   window_bypass_a: assert property (
      idle_req && !cpu_we && !int_sel && cache_en && in_win && !hit
      |=> state_q == cache_pkg::ST_BYPASS ##1 !fill_end)
      else $error("window miss allocated a line");
   sram_one_cycle_a: assert property (
      idle_req && int_sel |=> cpu_ready && !mem_req)
      else $error("internal access not answered in one cycle");
   flush_zero_a: assert property (
      idle_req && cpu_we && int_sel && is_lru && tag_ok && cpu_wdata[3:0] == 4'h0
      |=> lru_mem[$past(line)] == cache_pkg::CS_EMPTY)
      else $error("set-state entry not cleared");
   half_victim_a: assert property (
      idle_req && !cpu_we && !int_sel && !hit && cacheable && half |=> !victim_q[1])
      else $error("half mode filled an SRAM way");
   hit_answer_a: assert property (
      idle_req && !cpu_we && hit |=> cpu_ready && !mem_req && cpu_rdata == $past(hit_data))
      else $error("read hit not answered from cache");
   write_miss_a: assert property (
      idle_req && cpu_we && !int_sel && !hit |-> !dwr_en)
      else $error("write miss wrote the cache");

   fill_done_c: cover property (fill_end ##1 cpu_ready);
   read_hit_c: cover property (idle_req && !cpu_we && hit && cs[3]);
   bypass_c: cover property (state_q == cache_pkg::ST_BYPASS && mem_ack && cache_en);
   sram_write_c: cover property (idle_req && cpu_we && int_sel && is_data && data_ok && half);
endmodule
`default_nettype wire

/* sim/ext_mem_model.sv */
/*
 External memory model on the far side of the cache's memory port.
 Assumes one word per request, answered by a one-cycle mem_ack pulse.
*/
`default_nettype none
module ext_mem_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [1:0] lag,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   output logic [31:0] n_rd,
   output logic [31:0] n_wr,
   output logic [31:0] last_wa,
   output logic [31:0] last_wd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q; // Idle cycles spent on the current word

   // Answer after lag cycles; read data is the inverted address so each word differs.
   // Outside an answer the data bus toggles, so a stale sample never looks right.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         wait_q <= 2'h0;
         n_rd <= 32'h0;
         n_wr <= 32'h0;
         last_wa <= 32'h0;
         last_wd <= 32'h0;
      end
      else if (mem_req && !mem_ack && wait_q == lag)
      begin
         mem_ack <= 1'b1;
         wait_q <= 2'h0;
         mem_rdata <= mem_we ? ~mem_rdata : ~mem_addr;
         n_rd <= n_rd + {31'h0, !mem_we};
         n_wr <= n_wr + {31'h0, mem_we};
         last_wa <= mem_we ? mem_addr : last_wa;
         last_wd <= mem_we ? mem_wdata : last_wd;
      end
      else
      begin
         // Hold the answer back while slow; the ack stays one cycle
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

/* sim/test_unified_cache_with_sram_mode.sv */
/*
 Self-checking bench for the unified cache: register, core and memory traffic.
 Assumes the memory model of ext_mem_model and the package cache_pkg.
*/
`default_nettype none
module test_unified_cache_with_sram_mode;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, resetn, reg_write, reg_read, cpu_req, cpu_we, cpu_ready, mem_req, mem_we, mem_ack;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, cpu_addr, cpu_wdata, cpu_rdata;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, n_rd, n_wr, last_wa, last_wd;
   logic [1:0] lag; // Memory answer delay
   int n_fail, samples_checked, cycles;
   int fw[4] = '{0, 2, 1, 3}; // Way filled by each successive miss
   logic [3:0] cs_tab[4] = '{4'h8, 4'hA, 4'hC, 4'hD}; // Full states, victim way k
   logic [31:0] wa[8] = '{32'h22FF0, 32'h22FF0, 32'h10000, 32'h23000, 32'h40000,
      32'h40000, 32'h0F000, 32'h41000};
   int wn[8] = '{1, 1, 1, 4, 1, 1, 4, 4}; // Memory reads per window access
   localparam logic [31:0] A0 = 32'h00100030; // Line 3, first tag
   localparam logic [31:0] B0 = 32'h00200030; // Line 3, victim probes
   localparam logic [31:0] SS = 32'h10004030; // Set-state entry of line 3
   localparam logic [31:0] CFG = cache_pkg::CFG_ADDR;

   unified_cache dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   ext_mem_model mem_u (.clock(clock), .resetn(resetn), .lag(lag), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .n_rd(n_rd), .n_wr(n_wr), .last_wa(last_wa), .last_wd(last_wd));

   // Free-running 50 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Hang guard: the whole sequence needs a few hundred cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         finish_test();
      end
   end

   task finish_test();
      $display("Checks made %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task reg_rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // One core access held until ready; checks data, memory traffic and latency
   task acc(input logic we, input logic [31:0] a, input logic [31:0] d,
      input logic [31:0] exp, input int rd, input int wr, input int cyc);
      logic [31:0] r0, w0;
      int c;
      r0 = n_rd;
      w0 = n_wr;
      c = 0;
      @(posedge clock);
      cpu_req <= 1'b1;
      cpu_we <= we;
      cpu_addr <= a;
      cpu_wdata <= d;
      do
      begin
         @(posedge clock);
         #1;
         c++;
      end while (cpu_ready !== 1'b1 && c < 100);
      // A core access that never completes counts against the run
      if (cpu_ready !== 1'b1)
         n_fail++;
      if (!we)
         chk(cpu_rdata, exp);
      @(posedge clock);
      cpu_req <= 1'b0;
      #1;
      chk(n_rd - r0, 32'(rd));
      chk(n_wr - w0, 32'(wr));
      if (wr > 0)
      begin
         chk(last_wa, a);
         chk(last_wd, d);
      end
      if (cyc > 0)
         chk(32'(c), 32'(cyc));
   endtask

   initial
   begin
      {resetn, reg_write, reg_read, cpu_req, cpu_we, lag} = '0;
      {reg_addr, reg_wdata, cpu_addr, cpu_wdata} = '0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      reg_rd(CFG, 32'h01);
      reg_rd(cache_pkg::WIN0_ADDR, 32'h0);
      reg_rd(CFG + 32'hC, 32'h0);
      reg_wr(CFG, 32'hFF);
      reg_rd(CFG, 32'h3F);
      reg_wr(CFG, 32'h01);
      // Disabled: reads bypass and never allocate
      acc(1'b0, A0, 0, ~A0, 1, 0, 0);
      acc(1'b0, A0, 0, ~A0, 1, 0, 0);
      acc(1'b1, SS, 32'hA, 0, 0, 0, 1);
      acc(1'b0, SS, 0, 32'hA, 0, 0, 1);
      acc(1'b1, SS, 0, 0, 0, 0, 1);
      // Four fills of one line, then inspect state and tags
      reg_wr(CFG, 32'h07);
      for (int k = 0; k < 4; k++)
         acc(1'b0, A0 + k * 32'h800 + 4, 0, ~(A0 + k * 32'h800 + 4), 4, 0, 0);
      reg_wr(CFG, 32'h01);
      acc(1'b0, SS, 0, 32'h8, 0, 0, 1);
      for (int k = 0; k < 4; k++)
         acc(1'b0, 32'h10002030 + fw[k] * 32'h800, 0, (A0 + k * 32'h800) & 32'hFFFFF800,
            0, 0, 1);
      reg_wr(CFG, 32'h07);
      for (int k = 0; k < 4; k++)
         acc(1'b0, A0 + k * 32'h800 + 8, 0, ~(A0 + k * 32'h800 + 8), 0, 0, 1);
      // Victim choice for one full-line state per victim way
      for (int k = 0; k < 4; k++)
      begin
         reg_wr(CFG, 32'h01);
         acc(1'b1, SS, {28'h0, cs_tab[k]}, 0, 0, 0, 1);
         reg_wr(CFG, 32'h07);
         acc(1'b0, B0 + k * 32'h800, 0, ~(B0 + k * 32'h800), 4, 0, 0);
         reg_wr(CFG, 32'h01);
         acc(1'b0, 32'h10002030 + k * 32'h800, 0, (B0 + k * 32'h800) & 32'hFFFFF800,
            0, 0, 1);
      end
      // Flush by zeroing state, then the line misses again
      acc(1'b1, SS, 0, 0, 0, 0, 1);
      reg_wr(CFG, 32'h07);
      acc(1'b0, B0 + 32'h1800, 0, ~(B0 + 32'h1800), 4, 0, 0);
      // Write-through on hit, then on miss with slow memory
      acc(1'b1, B0 + 32'h1800, 32'h12345678, 0, 0, 1, 0);
      acc(1'b0, B0 + 32'h1800, 0, 32'h12345678, 0, 0, 1);
      lag <= 2'h3;
      acc(1'b1, 32'h00300000, 32'h5A5A0F0F, 0, 0, 1, 0);
      acc(1'b0, 32'h00300000, 0, ~32'h00300000, 4, 0, 0);
      // Uncached windows in 4KB blocks, end exclusive
      reg_wr(cache_pkg::WIN0_ADDR, 32'h00230010);
      reg_rd(cache_pkg::WIN0_ADDR, 32'h00230010);
      reg_wr(cache_pkg::WIN1_ADDR, 32'h00410040);
      for (int k = 0; k < 8; k++)
         acc(1'b0, wa[k], 0, ~wa[k], wn[k], 0, 0);
      // Half mode: ways 2 and 3 become SRAM
      lag <= 2'h0;
      reg_wr(CFG, 32'h03);
      acc(1'b1, 32'h10001000, 32'hCAFE0001, 0, 0, 0, 1);
      acc(1'b0, 32'h10001000, 0, 32'hCAFE0001, 0, 0, 1);
      acc(1'b0, 32'h10000000, 0, 0, 0, 0, 1);
      acc(1'b0, 32'h00500040, 0, ~32'h00500040, 4, 0, 0);
      acc(1'b0, 32'h00500040, 0, ~32'h00500040, 0, 0, 1);
      // Disabled: whole store is SRAM
      reg_wr(CFG, 32'h01);
      acc(1'b1, 32'h10000000, 32'h0BADF00D, 0, 0, 0, 1);
      acc(1'b0, 32'h10000000, 0, 32'h0BADF00D, 0, 0, 1);
      // Reserved mode 10: no SRAM ways, reads go outside
      reg_wr(CFG, 32'h05);
      acc(1'b0, 32'h10000000, 0, 0, 0, 0, 1);
      acc(1'b0, A0, 0, ~A0, 1, 0, 0);
      finish_test();
   end
endmodule
`default_nettype wire
